// ---- inc/clpm_cfg.svh ----
// offsets, field positions and timing counts of the low-power mode control block
// assumes a 100 MHz clock and an 8-bit apb byte address
`ifndef CLPM_CFG_SVH
`define CLPM_CFG_SVH
`define CLPM_OFF_CTRL 8'h00
`define CLPM_OFF_STAT 8'h04
`define CLPM_OFF_ISTAT 8'h08
`define CLPM_OFF_IMASK 8'h0c
`define CLPM_OFF_TXSEL 8'h10
`define CLPM_OFF_TXE 8'h14
`define CLPM_OFF_RXF 8'h18
`define CLPM_WIN_TX 4'h4
`define CLPM_WIN_RX 4'h6
`define CLPM_CTRL_SLEEP_REQUEST 0
`define CLPM_CTRL_WAKEUP_ENABLE_BIT 1
`define CLPM_CTRL_WFILT 2
`define CLPM_CTRL_CSW 3
`define CLPM_EV_WAKE 0
`define CLPM_EV_ABORT 1
`define CLPM_EV_RECOV 2
`define CLPM_EV_RXF 3
`define CLPM_NEV 4
`define CLPM_NBUF 3
`define CLPM_NWORD 4
`define CLPM_TXE_RST 3'h7
`define CLPM_CLK_NS 10
`define CLPM_RECOV_NS 1000
`define CLPM_RECOV_CYC ((`CLPM_RECOV_NS + `CLPM_CLK_NS - 1) / `CLPM_CLK_NS)
`define CLPM_WFILT_NS 2000
`define CLPM_WFILT_CYC ((`CLPM_WFILT_NS + `CLPM_CLK_NS - 1) / `CLPM_CLK_NS)
`endif

// ---- inc/clpm_pkg.sv ----
// types of the low-power mode control block
// shared by the design and the bench
package clpm_pkg;
    typedef enum logic [3:0] {
        M_NORMAL = 4'h1,
        M_SLEEP = 4'h2,
        M_PDOWN = 4'h4,
        M_RECOV = 4'h8
    } clpm_mode_t;
    typedef enum logic [1:0] {
        CPU_RUN = 2'h0,
        CPU_WAIT = 2'h1,
        CPU_STOP3 = 2'h2,
        CPU_STOP12 = 2'h3
    } clpm_cpu_t;
    typedef struct packed {
        logic ide;
        logic srr;
        logic rtr;
        logic [28:0] id;
        logic [63:0] data;
        logic [3:0] dlc;
    } clpm_rxfrm_t;
endpackage

// ---- logic/clpm_ctrl.sv ----
// low-power mode control of a can controller, with message buffer access over apb
// assumes synchronous inputs, a protocol engine outside and one 100 MHz clock
// Function
// - in run mode only sleep is offered, never power-down
// - deep stop, shallow stop without sleep at entry, or wait with stop-clocks-in-wait, gives power-down
// - wait without stop-clocks-in-wait keeps normal or sleep per request
// - deep stop modes force power-down whatever sleep request and acknowledge
// - shallow stop picks sleep if request and acknowledge were 1 at entry
// - stop-clocks-in-wait is ignored in every stop mode
// - entering power-down aborts traffic and drives transmit pin recessive
// - power-down freezes all software-visible state and refuses every register access
// - power-down without prior sleep runs a fixed recovery delay after it
// - leaving wait-induced power-down restarts and returns to normal, or returns to sleep if sleep preceded it
// - with wake-up enabled, bus activity ends sleep
// - wake-up filter select ignores short glitches on the receive line
// - transmit buffer writable only when empty and selected; receive read-only
// - receive buffer reads are valid only while receive-full is set
// - message buffers are not reset, contents undefined after reset
// - identifier word holds 32 bits extended or 13 bits standard
`include "clpm_cfg.svh"
module clpm_ctrl import clpm_pkg::*; (
    // clock, reset, enable
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // processor state
    input wire clpm_cpu_t cpu_mode_in,
    // can pins and protocol engine
    input wire logic can_receive_pin_in,
    input wire logic tx_engine_bit_in,
    input wire logic bus_idle_in,
    input wire logic rx_store_in,
    input wire clpm_rxfrm_t rx_frame_in,
    input wire logic [2:0] tx_sent_in,
    output logic can_transmit_pin_out,
    output logic engine_abort_out,
    output logic [2:0] tx_pending_out,
    // status
    output logic irq_out,
    output clpm_mode_t mode_out
);
    localparam logic [7:0] RECOV_CYC = 8'(`CLPM_RECOV_CYC);
    localparam logic [7:0] WFILT_CYC = 8'(`CLPM_WFILT_CYC);
    localparam int RECOV_INT = `CLPM_RECOV_CYC;

    clpm_mode_t state_q, state_d;
    clpm_cpu_t prev_cpu_q;
    logic [3:0] ctrl_q, ctrl_d;
    logic [`CLPM_NEV-1:0] istat_q, imask_q;
    logic [2:0] txsel_q, txe_q;
    logic rxf_q, from_sleep_q, s3_sleep_q;
    logic [7:0] rec_cnt_q, wcnt_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q, irq_q, txpin_q, abort_q;
    logic [2:0] txpend_q;
    // ram-backed buffers, deliberately without reset
    logic [31:0] tx_mem [0:`CLPM_NBUF*`CLPM_NWORD-1];
    logic [31:0] rx_mem [0:`CLPM_NWORD-1];

    wire ce = clk_en_in;
    wire pd = (state_q == M_PDOWN);
    wire sleep_request = ctrl_q[`CLPM_CTRL_SLEEP_REQUEST];
    wire wakeup_enable_bit = ctrl_q[`CLPM_CTRL_WAKEUP_ENABLE_BIT];
    wire wakeup_filter_select = ctrl_q[`CLPM_CTRL_WFILT];
    wire stop_clocks_in_wait = ctrl_q[`CLPM_CTRL_CSW];
    wire sleep_acknowledge = (state_q == M_SLEEP);

    // apb decode
    wire setup = psel_in & ~penable_in;
    wire access = psel_in & penable_in & pready_q;
    wire wr = access & pwrite_in & ~pslverr_q;
    wire a_ctrl = (paddr_in == `CLPM_OFF_CTRL);
    wire a_stat = (paddr_in == `CLPM_OFF_STAT);
    wire a_istat = (paddr_in == `CLPM_OFF_ISTAT);
    wire a_imask = (paddr_in == `CLPM_OFF_IMASK);
    wire a_txsel = (paddr_in == `CLPM_OFF_TXSEL);
    wire a_txe = (paddr_in == `CLPM_OFF_TXE);
    wire a_rxf = (paddr_in == `CLPM_OFF_RXF);
    wire a_tx = (paddr_in[7:4] == `CLPM_WIN_TX) & (paddr_in[1:0] == 2'h0);
    wire a_rx = (paddr_in[7:4] == `CLPM_WIN_RX) & (paddr_in[1:0] == 2'h0);
    wire [1:0] word = paddr_in[3:2];
    wire mapped = a_ctrl | a_stat | a_istat | a_imask | a_txsel | a_txe | a_rxf | a_tx | a_rx;

    // lowest selected transmit buffer
    wire [1:0] sel_idx = txsel_q[0] ? 2'h0 : (txsel_q[1] ? 2'h1 : 2'h2);
    wire sel_ok = (|txsel_q) & txe_q[sel_idx];
    wire [3:0] tx_addr = 4'(sel_idx * 4) + {2'h0, word};
    // writes only to an empty, selected buffer
    wire tx_wr = wr & a_tx & sel_ok;

    // stop3 decides from the sleep state present at entry
    wire s3_entry = (cpu_mode_in == CPU_STOP3) & (prev_cpu_q != CPU_STOP3);
    wire s3_sleep = s3_entry ? (sleep_request & sleep_acknowledge) : s3_sleep_q;
    wire pd_cond = (cpu_mode_in == CPU_STOP12) |
                   ((cpu_mode_in == CPU_WAIT) & stop_clocks_in_wait) |
                   ((cpu_mode_in == CPU_STOP3) & ~s3_sleep);

    wire rx_dom = ~can_receive_pin_in;
    wire wake_ev = sleep_acknowledge & wakeup_enable_bit & rx_dom & (~wakeup_filter_select | (wcnt_q == WFILT_CYC - 8'h1));

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            M_NORMAL: begin
                if (pd_cond) begin
                    state_d = M_PDOWN;
                end else if (sleep_request & bus_idle_in) begin
                    state_d = M_SLEEP;
                end
            end
            M_SLEEP: begin
                if (pd_cond) begin
                    state_d = M_PDOWN;
                end else if (wake_ev | ~sleep_request) begin
                    state_d = M_NORMAL;
                end
            end
            // leave power-down through recovery unless sleep preceded it
            M_PDOWN: begin
                if (!pd_cond) begin
                    state_d = from_sleep_q ? M_SLEEP : M_RECOV;
                end
            end
            M_RECOV: begin
                if (pd_cond) begin
                    state_d = M_PDOWN;
                end else if (rec_cnt_q == 8'h1) begin
                    state_d = M_NORMAL;
                end
            end
        endcase
    end

    wire enter_pd = (state_d == M_PDOWN) & ~pd;
    wire recov_done = (state_q == M_RECOV) & (state_d == M_NORMAL);
    wire rx_set = rx_store_in & ~rxf_q & ~pd;
    wire [`CLPM_NEV-1:0] events = {rx_set, recov_done, enter_pd & ~bus_idle_in,
                                  (state_d == M_NORMAL) & wake_ev};

    // control register, hardware drops the sleep request on wake-up
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr & a_ctrl) begin
            ctrl_d = pwdata_in[3:0];
        end
        if (events[`CLPM_EV_WAKE]) begin
            ctrl_d[`CLPM_CTRL_SLEEP_REQUEST] = 1'b0;
        end
    end

    // identifier word, extended uses 32 bits, standard only 13
    function automatic logic [31:0] pack_id(input clpm_rxfrm_t f);
        logic [31:0] w;
        w = 32'h0;
        if (f.ide) begin
            w = {f.id, f.srr, 1'b1, f.rtr};
        end else begin
            w[31:19] = {f.id[10:0], f.rtr, 1'b0};
        end
        return w;
    endfunction

    // read mux; receive window valid only while full
    logic [31:0] rd_d;
    always_comb begin
        rd_d = 32'h0;
        if (a_ctrl) rd_d[3:0] = ctrl_q;
        if (a_stat) rd_d[5:0] = {from_sleep_q, state_q, sleep_acknowledge};
        if (a_istat) rd_d[`CLPM_NEV-1:0] = istat_q;
        if (a_imask) rd_d[`CLPM_NEV-1:0] = imask_q;
        if (a_txsel) rd_d[2:0] = txsel_q;
        if (a_txe) rd_d[2:0] = txe_q;
        if (a_rxf) rd_d[0] = rxf_q;
        if (a_tx && (|txsel_q)) rd_d = tx_mem[tx_addr];
        if (a_rx && rxf_q) rd_d = rx_mem[word];
    end

    // apb answer: data captured in setup, ready in the first access cycle
    // power-down or unmapped address answers with an error and zero data
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else if (ce) begin
            pready_q <= setup;
            pslverr_q <= setup & (pd | ~mapped);
            prdata_q <= (setup & ~pd & ~pwrite_in) ? rd_d : 32'h0;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= M_NORMAL;
            prev_cpu_q <= CPU_RUN;
            s3_sleep_q <= 1'b0;
            from_sleep_q <= 1'b0;
        end else if (ce) begin
            state_q <= state_d;
            prev_cpu_q <= cpu_mode_in;
            s3_sleep_q <= s3_sleep;
            if (enter_pd) from_sleep_q <= sleep_acknowledge;
        end
    end

    // fixed recovery count, loaded on leaving power-down
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rec_cnt_q <= 8'h0;
        end else if (ce) begin
            if (state_d == M_RECOV && state_q != M_RECOV) rec_cnt_q <= RECOV_CYC;
            else if (state_q == M_RECOV) rec_cnt_q <= rec_cnt_q - 8'h1;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wcnt_q <= 8'h0;
        end else if (ce) begin
            wcnt_q <= (sleep_acknowledge & rx_dom & (wcnt_q != WFILT_CYC)) ? wcnt_q + 8'h1 :
                      (sleep_acknowledge & rx_dom) ? wcnt_q : 8'h0;
        end
    end

    // software-visible state holds still during power-down
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_q <= 4'h0;
            istat_q <= '0;
            imask_q <= '0;
            txsel_q <= 3'h0;
            txe_q <= `CLPM_TXE_RST;
            rxf_q <= 1'b0;
        end else if (ce && !pd) begin
            ctrl_q <= ctrl_d;
            // set wins over a write-one clear in the same cycle
            istat_q <= (istat_q & ~((wr & a_istat) ? pwdata_in[`CLPM_NEV-1:0] : '0)) | events;
            if (wr & a_imask) imask_q <= pwdata_in[`CLPM_NEV-1:0];
            if (wr & a_txsel) txsel_q <= pwdata_in[2:0];
            txe_q <= (txe_q & ~((wr & a_txe) ? pwdata_in[2:0] : 3'h0)) | tx_sent_in;
            rxf_q <= (rxf_q & ~(wr & a_rxf & pwdata_in[0])) | rx_set;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (ce && tx_wr) begin
            tx_mem[tx_addr] <= pwdata_in;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (ce && rx_set) begin
            rx_mem[0] <= pack_id(rx_frame_in);
            rx_mem[1] <= rx_frame_in.data[63:32];
            rx_mem[2] <= rx_frame_in.data[31:0];
            rx_mem[3] <= {28'h0, rx_frame_in.dlc};
        end
    end

    // outputs
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_q <= 1'b0;
            txpin_q <= 1'b1;
            abort_q <= 1'b0;
            txpend_q <= 3'h0;
        end else if (ce) begin
            irq_q <= |(istat_q & imask_q);
            // recessive and abort from the cycle power-down starts
            txpin_q <= (state_d == M_PDOWN) ? 1'b1 : tx_engine_bit_in;
            abort_q <= (state_d == M_PDOWN);
            txpend_q <= ~txe_q;
        end
    end

    assign prdata_out = prdata_q;
    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;
    assign can_transmit_pin_out = txpin_q;
    assign engine_abort_out = abort_q;
    assign tx_pending_out = txpend_q;
    assign irq_out = irq_q;
    assign mode_out = state_q;

    // checks
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    logic [7:0] rec_seen_q;
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) rec_seen_q <= 8'h0;
        else if (ce) rec_seen_q <= (state_q == M_RECOV) ? rec_seen_q + 8'h1 : 8'h0;
    end

    sequence pd_setup_s;
        ce && setup && pd;
    endsequence
    sequence refused_s;
        pready_out && pslverr_out && (prdata_out == 32'h0);
    endsequence
    sequence rx_empty_read_s;
        ce && setup && !pwrite_in && a_rx && !rxf_q && !pd;
    endsequence

    chk_run_no_pd: assert property (
        (ce && cpu_mode_in == CPU_RUN && !pd) |=> state_q != M_PDOWN)
        else $error("power-down entered in run mode");
    chk_deep_stop: assert property (
        (ce && cpu_mode_in == CPU_STOP12) |=> state_q == M_PDOWN)
        else $error("deep stop did not force power-down");
    chk_wait_csw_pd: assert property (
        (ce && cpu_mode_in == CPU_WAIT && stop_clocks_in_wait) |=> state_q == M_PDOWN)
        else $error("clock-stopping wait did not power down");
    chk_wait_normal: assert property (
        (ce && cpu_mode_in == CPU_WAIT && !stop_clocks_in_wait && state_q == M_NORMAL && !sleep_request)
        |=> state_q == M_NORMAL)
        else $error("plain wait left normal mode");
    chk_stop3_sleep: assert property (
        (ce && s3_entry && sleep_acknowledge && sleep_request) |=> state_q == M_SLEEP)
        else $error("shallow stop left sleep despite request");
    chk_tx_recessive: assert property (
        (ce && cpu_mode_in == CPU_STOP12) |=> can_transmit_pin_out && engine_abort_out)
        else $error("transmit pin not recessive in power-down");
    chk_pd_refused: assert property (
        pd_setup_s ##1 ce |-> refused_s)
        else $error("register access granted in power-down");
    chk_recov_len: assert property (
        rec_seen_q <= 8'(RECOV_INT))
        else $error("recovery lasted too long");
    chk_wake_plain: assert property (
        (ce && sleep_acknowledge && sleep_request && wakeup_enable_bit && !wakeup_filter_select && rx_dom && !pd_cond)
        |=> state_q == M_NORMAL)
        else $error("no wake-up on bus activity");
    chk_glitch_filter: assert property (
        (ce && sleep_acknowledge && sleep_request && wakeup_enable_bit && wakeup_filter_select && wcnt_q == 8'h0 && rx_dom && !pd_cond)
        |=> state_q == M_SLEEP)
        else $error("filtered wake-up took a glitch");
    chk_rx_invalid: assert property (
        rx_empty_read_s ##1 ce |-> prdata_out == 32'h0)
        else $error("receive buffer read while not full");
    chk_s3_pdown: assert property (
        (ce && s3_entry && !(sleep_request && sleep_acknowledge)) |=> state_q == M_PDOWN)
        else $error("shallow stop without sleep kept running");
    chk_pd_to_recov: assert property (
        (ce && pd && !pd_cond && !from_sleep_q) |=> state_q == M_RECOV)
        else $error("no recovery after power-down");
    chk_pd_to_sleep: assert property (
        (ce && pd && !pd_cond && from_sleep_q) |=> state_q == M_SLEEP)
        else $error("power-down from sleep did not return to sleep");
    chk_recov_stop: assert property (
        (ce && state_q == M_RECOV && pd_cond) |=> state_q == M_PDOWN)
        else $error("recovery ignored a stop request");
    chk_sleep_entry: assert property (
        (ce && state_q == M_NORMAL && sleep_request && bus_idle_in && !pd_cond)
        |=> state_q == M_SLEEP)
        else $error("sleep request on idle bus not taken");
endmodule

// ---- tb/clpm_bus_model.sv ----
// can bus model: recessive idle line, dominant bursts on request
// assumes the bench pulses start_in for one cycle at a rising edge
module clpm_bus_model (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // request from the bench
    input wire logic start_in,
    input wire logic [8:0] len_in,
    // bus side
    output logic rx_pin_out,
    output logic idle_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] cnt_q;
    // the termination pulls an undriven bus back to recessive
    assign rx_pin_out = (cnt_q == 9'h000);
    assign idle_out = (cnt_q == 9'h000);
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_q <= 9'h000;
        end else if (start_in) begin
            cnt_q <= len_in;
        end else if (cnt_q != 9'h000) begin
            cnt_q <= cnt_q - 9'h001;
        end
    end
endmodule

// ---- tb/clpm_ctrl_tb.sv ----
// self-checking bench of the low-power mode control block
// assumes the bus model beside it and a 100 MHz clock
`include "clpm_cfg.svh"
module clpm_ctrl_tb import clpm_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, txbit = 1'b1, store = 1'b0, txpin, abort, irq;
    logic bstart = 1'b0, rxpin, idle;
    logic [8:0] blen = 9'h000;
    logic [2:0] sent = 3'h0, pend;
    clpm_cpu_t cpu = CPU_RUN;
    clpm_rxfrm_t frm = '0;
    clpm_mode_t mode;
    int err_count = 0, total_checks = 0, n;
    always #5 clk = ~clk;
    clpm_bus_model bus_u (.ref_clk_in(clk), .rst_in(rst), .start_in(bstart), .len_in(blen),
        .rx_pin_out(rxpin), .idle_out(idle));
    clpm_ctrl dut_u (.ref_clk_in(clk), .rst_in(rst), .clk_en_in(1'b1), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .cpu_mode_in(cpu),
        .can_receive_pin_in(rxpin), .tx_engine_bit_in(txbit), .bus_idle_in(idle),
        .rx_store_in(store), .rx_frame_in(frm), .tx_sent_in(sent),
        .can_transmit_pin_out(txpin), .engine_abort_out(abort), .tx_pending_out(pend),
        .irq_out(irq), .mode_out(mode));
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic fail(input string m);
        $display("unexpected at %0t ns: %s", $time, m);
        err_count++;
    endtask
    function automatic bit nck(input bit bad);
        total_checks++;
        return bad;
    endfunction
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        // pready, prdata and pslverr are taken as they stood at the sampling edge
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) begin
            fail("no ready");
            print_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] x, input logic e);
        apb(1'b0, a, 32'h0);
        if (nck(rd !== x || err !== e)) fail($sformatf("read %h gave %h", a, rd));
    endtask
    task automatic wmode(input clpm_mode_t m, input int lim);
        n = 0;
        while (mode !== m && n < lim) begin
            @(negedge clk);
            n++;
        end
        if (nck(mode !== m)) begin
            fail("mode not reached");
            print_verdict();
        end
    endtask
    task automatic hold(input clpm_mode_t m, input int k);
        bit bad = 1'b0;
        repeat (k) begin
            @(negedge clk);
            bad |= (mode !== m);
        end
        if (nck(bad)) fail("mode left");
    endtask
    task automatic setcpu(input clpm_cpu_t c);
        @(posedge clk);
        cpu <= c;
    endtask
    task automatic burst(input logic [8:0] l);
        @(posedge clk);
        bstart <= 1'b1;
        blen <= l;
        @(posedge clk);
        bstart <= 1'b0;
        repeat (l + 4) @(negedge clk);
    endtask
    task automatic putfrm(input clpm_rxfrm_t f);
        @(posedge clk);
        frm <= f;
        store <= 1'b1;
        @(posedge clk);
        store <= 1'b0;
    endtask
    task automatic t_pdown();
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, `CLPM_OFF_CTRL, (i == 1) ? 32'h8 : 32'h0);
            txbit <= 1'b0;
            repeat (2) @(negedge clk);
            if (nck(txpin !== 1'b0)) fail("tx bit not passed");
            // a frame on the bus when power-down hits must flag an abort
            if (i == 0) begin
                @(posedge clk);
                bstart <= 1'b1;
                blen <= 9'h040;
                @(posedge clk);
                bstart <= 1'b0;
            end
            setcpu((i == 1) ? CPU_WAIT : CPU_STOP12);
            wmode(M_PDOWN, 3);
            if (nck(txpin !== 1'b1 || abort !== 1'b1)) fail("no abort");
            rchk(`CLPM_OFF_STAT, 32'h0, 1'b1);
            setcpu(CPU_RUN);
            wmode(M_RECOV, 3);
            wmode(M_NORMAL, 110);
            if (nck(n != 100)) fail("recovery length");
            rchk(`CLPM_OFF_ISTAT, (i == 0) ? 32'h6 : 32'h4, 1'b0);
            apb(1'b1, `CLPM_OFF_ISTAT, 32'h6);
        end
        apb(1'b1, `CLPM_OFF_CTRL, 32'h0);
        $display("power-down test done");
    endtask
    task automatic t_modes();
        apb(1'b1, `CLPM_OFF_CTRL, 32'h0);
        setcpu(CPU_WAIT);
        hold(M_NORMAL, 20);
        apb(1'b1, `CLPM_OFF_CTRL, 32'h1);
        wmode(M_SLEEP, 10);
        rchk(`CLPM_OFF_STAT, 32'h5, 1'b0);
        setcpu(CPU_RUN);
        apb(1'b1, `CLPM_OFF_CTRL, 32'h9);
        hold(M_SLEEP, 10);
        setcpu(CPU_STOP3);
        hold(M_SLEEP, 20);
        setcpu(CPU_STOP12);
        wmode(M_PDOWN, 3);
        setcpu(CPU_RUN);
        wmode(M_SLEEP, 3);
        apb(1'b1, `CLPM_OFF_CTRL, 32'h0);
        wmode(M_NORMAL, 10);
        setcpu(CPU_STOP3);
        wmode(M_PDOWN, 3);
        setcpu(CPU_RUN);
        wmode(M_RECOV, 3);
        wmode(M_NORMAL, 110);
        apb(1'b1, `CLPM_OFF_ISTAT, 32'h4);
        $display("mode selection test done");
    endtask
    task automatic t_wake();
        apb(1'b1, `CLPM_OFF_CTRL, 32'h7);
        wmode(M_SLEEP, 10);
        burst(9'h096);
        if (nck(mode !== M_SLEEP)) fail("glitch woke");
        burst(9'h0fa);
        if (nck(mode !== M_NORMAL || irq !== 1'b0)) fail("no wake");
        rchk(`CLPM_OFF_ISTAT, 32'h1, 1'b0);
        apb(1'b1, `CLPM_OFF_IMASK, 32'h1);
        repeat (2) @(negedge clk);
        if (nck(irq !== 1'b1)) fail("irq low");
        apb(1'b1, `CLPM_OFF_ISTAT, 32'h1);
        repeat (2) @(negedge clk);
        if (nck(irq !== 1'b0)) fail("irq stuck");
        apb(1'b1, `CLPM_OFF_CTRL, 32'h3);
        wmode(M_SLEEP, 10);
        burst(9'h003);
        if (nck(mode !== M_NORMAL)) fail("unfiltered no wake");
        apb(1'b1, `CLPM_OFF_ISTAT, 32'h1);
        $display("wake-up test done");
    endtask
    task automatic t_buffers();
        rchk(`CLPM_OFF_TXE, 32'h7, 1'b0);
        rchk(8'h60, 32'h0, 1'b0);
        putfrm({3'h6, 29'h12345678, 64'h0011223344556677, 4'h8});
        rchk(`CLPM_OFF_RXF, 32'h1, 1'b0);
        rchk(`CLPM_OFF_ISTAT, 32'h8, 1'b0);
        rchk(8'h60, {29'h12345678, 3'h6}, 1'b0);
        rchk(8'h64, 32'h00112233, 1'b0);
        rchk(8'h68, 32'h44556677, 1'b0);
        rchk(8'h6c, 32'h8, 1'b0);
        apb(1'b1, 8'h60, 32'h0);
        rchk(8'h60, {29'h12345678, 3'h6}, 1'b0);
        apb(1'b1, `CLPM_OFF_RXF, 32'h1);
        rchk(8'h60, 32'h0, 1'b0);
        putfrm({3'h1, 29'h5a5, 64'h0, 4'h0});
        rchk(8'h60, {11'h5a5, 2'h2, 19'h0}, 1'b0);
        rchk(8'h2c, 32'h0, 1'b1);
        apb(1'b1, `CLPM_OFF_TXSEL, 32'h1);
        apb(1'b1, 8'h40, 32'h00000a5c);
        rchk(8'h40, 32'h00000a5c, 1'b0);
        apb(1'b1, `CLPM_OFF_TXE, 32'h1);
        repeat (2) @(negedge clk);
        if (nck(pend !== 3'h1)) fail("not pending");
        apb(1'b1, 8'h40, 32'h00001234);
        rchk(8'h40, 32'h00000a5c, 1'b0);
        @(posedge clk);
        sent <= 3'h1;
        @(posedge clk);
        sent <= 3'h0;
        repeat (2) @(negedge clk);
        if (nck(pend !== 3'h0)) fail("still pending");
        $display("buffer test done");
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_pdown();
        t_modes();
        t_wake();
        t_buffers();
        print_verdict();
    end
endmodule
